// ### pegp_pins.sv
// Pin and host model at the far side of lines 0..2
`timescale 1ns/10ps
module pegp_pins (
  // Design side
  input wire logic [2:0] line_out,
  input wire logic [2:0] line_oe_n,
  // Host drive enables and values
  input wire logic [2:0] host_en,
  input wire logic [2:0] host_val,
  // Resolved levels
  output logic [2:0] line_in
);
  // Pull-ups keep released strobes inactive; the block wins while it drives
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      line_in[i] = !line_oe_n[i] ? line_out[i] : (host_en[i] ? host_val[i] : 1'b1);
    end
  end
endmodule

// ### pegp_pkg.sv
// Package for the upper port GPIO block: offsets, fields, reset values
package pegp_pkg;
  // Register byte addresses on APB
  localparam logic [7:0] ADDR_PINS = 8'h00;
  localparam logic [7:0] ADDR_LATCH = 8'h04;
  localparam logic [7:0] ADDR_DIR = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
  localparam logic [7:0] ADDR_SLAVE_CTRL = 8'h14;
  // Direction register fields
  localparam int DIR_IN_FULL_BIT = 7;
  localparam int DIR_OUT_FULL_BIT = 6;
  localparam int DIR_OVERRUN_BIT = 5;
  localparam int DIR_MODE_BIT = 4;
  localparam logic [7:0] DIR_WRITE_MASK = 8'h37;
  // Reset values
  localparam logic [2:0] DIR_LINES_RESET = 3'h7;
  localparam logic [2:0] LATCH_RESET = 3'h0;
  localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
  // Slave control register fields (own register)
  localparam int SCTRL_SET_IN_FULL_BIT = 0;
  localparam int SCTRL_CLR_IN_FULL_BIT = 1;
  localparam int SCTRL_SET_OUT_FULL_BIT = 2;
  localparam int SCTRL_CLR_OUT_FULL_BIT = 3;
  // Interrupt status fields
  localparam int IRQ_IN_FULL_BIT = 0;
  localparam int IRQ_OUT_READ_BIT = 1;
  localparam int IRQ_OVERRUN_BIT = 2;
  localparam int IRQ_HV_BIT = 3;
endpackage

// ### pegp_port.sv
// Upper four-line port: direction, latch, pin read and slave-port status
//
// Behaviour
// - Large package gives four lines, three individually settable as input or output.
// - A line selected as analog reads back as zero.
// - Direction one floats the driver; zero drives the latch value.
// - Direction bits still steer drivers while lines are analog.
// - After reset the three configurable lines are analog inputs.
// - Latch register reads give latched values, not pin levels.
// - With reset-pin disabled line 3 is a plain input, else external reset.
// - Small package has only line 3, present only with reset-pin disabled.
// - Unimplemented direction register bits read zero, ignore writes.
// - Bit 7 shows a received word waits for the processor.
// - Bit 6 shows an output word not yet read externally.
// - Bit 5 sets on external write over unread word; software clears it.
// - Bit 4 selects slave port mode when one, GPIO when zero.
// - Slave mode uses line0 read, line1 write, line2 select; inputs required.
// - Direction zero drives the latch regardless of analog selection.
// - High-voltage detection on line 3 works at all times.
`timescale 1ns/10ps
module pegp_port #(
  parameter bit LARGE_PACKAGE = 1'b1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Lines 0..2, two-way; enable low while driving
  input wire logic [2:0] line_in,
  output logic [2:0] line_out,
  output logic [2:0] line_oe_n,
  // Line 3 and its functions
  input wire logic line3_input,
  input wire logic line3_high_voltage,
  output logic external_reset_input,
  output logic prog_entry_detect,
  // Outside configuration
  input wire logic [2:0] analog_select,
  input wire logic reset_pin_enable,
  // Slave port strobes toward the slave port block, active low, plus the active-high port select
  output logic slave_rd_n,
  output logic slave_wr_n,
  output logic slave_cs_n,
  output logic slave_port_select,
  // Slave port events from the slave port block
  input wire logic ext_write_done,
  input wire logic ext_read_done,
  input wire logic cpu_read_in,
  input wire logic cpu_write_out,
  // Interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////
  // State
  logic [2:0] dir_reg;
  logic [2:0] latch_reg;
  logic mode_reg;
  logic in_full_reg;
  logic out_full_reg;
  logic overrun_reg;
  logic [2:0] analog_reg;
  logic rpin_en_reg;
  logic [3:0] irq_stat_reg;
  logic [3:0] irq_mask_reg;
  logic hv_prev_reg;

  ////////////////////////////////////////////////////////////////////
  // APB decode; zero-wait slave
  wire wr_en = psel && penable && pwrite;
  wire hit_pins = paddr == pegp_pkg::ADDR_PINS;
  wire hit_latch = paddr == pegp_pkg::ADDR_LATCH;
  wire hit_dir = paddr == pegp_pkg::ADDR_DIR;
  wire hit_stat = paddr == pegp_pkg::ADDR_IRQ_STATUS;
  wire hit_mask = paddr == pegp_pkg::ADDR_IRQ_MASK;
  wire hit_sctrl = paddr == pegp_pkg::ADDR_SLAVE_CTRL;
  wire hit_any = hit_pins | hit_latch | hit_dir | hit_stat | hit_mask | hit_sctrl;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_any; // Unmapped address errors

  // Line availability: package for lines 0..2, reset-pin setting for line 3
  wire lines_ok = LARGE_PACKAGE;
  wire line3_ok = !rpin_en_reg;

  // Pin readback: analog lines read zero
  wire [2:0] pin_digital = line_in & ~analog_reg & {3{lines_ok}};
  wire [7:0] pins_val = {4'h0, line3_input & line3_ok, pin_digital};
  wire [7:0] latch_val = {5'h00, latch_reg & {3{lines_ok}}};
  wire [7:0] dir_val = {in_full_reg, out_full_reg, overrun_reg, mode_reg, 1'b0, dir_reg};

  // Read mux
  assign prdata = hit_pins ? {24'h000000, pins_val} :
                  hit_latch ? {24'h000000, latch_val} :
                  hit_dir ? {24'h000000, lines_ok ? dir_val : 8'h00} :
                  hit_stat ? {28'h0000000, irq_stat_reg} :
                  hit_mask ? {28'h0000000, irq_mask_reg} : 32'h00000000;

  ////////////////////////////////////////////////////////////////////
  // Line drivers: direction rules even over analog selection
  assign line_out = latch_reg;
  assign line_oe_n = dir_reg | {3{!lines_ok}};

  // Line 3 functions
  assign external_reset_input = rpin_en_reg ? line3_input : 1'b1;
  assign prog_entry_detect = line3_high_voltage;

  // Strobes only meaningful with direction set to input, software duty
  wire strobes_on = mode_reg && lines_ok;
  assign slave_rd_n = strobes_on ? pin_digital[0] : 1'b1;
  assign slave_wr_n = strobes_on ? pin_digital[1] : 1'b1;
  assign slave_cs_n = strobes_on ? pin_digital[2] : 1'b1;
  assign slave_port_select = strobes_on;

  ////////////////////////////////////////////////////////////////////
  // Outside configuration sampled each clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_reg <= pegp_pkg::DIR_LINES_RESET;
      rpin_en_reg <= 1'b1;
    end else begin
      analog_reg <= analog_select;
      rpin_en_reg <= reset_pin_enable;
    end
  end

  // Direction, mode and latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_reg <= pegp_pkg::DIR_LINES_RESET;
      mode_reg <= 1'b0;
      latch_reg <= pegp_pkg::LATCH_RESET;
    end else if (wr_en) begin
      if (hit_dir) begin
        dir_reg <= pwdata[2:0];
        mode_reg <= pwdata[pegp_pkg::DIR_MODE_BIT];
      end
      if (hit_latch || hit_pins) begin
        latch_reg <= pwdata[2:0];
      end
    end
  end

  // Slave status bits; hardware set wins over clear
  wire set_in = ext_write_done || (wr_en && hit_sctrl && pwdata[pegp_pkg::SCTRL_SET_IN_FULL_BIT]);
  wire clr_in = cpu_read_in || (wr_en && hit_sctrl && pwdata[pegp_pkg::SCTRL_CLR_IN_FULL_BIT]);
  wire set_out = cpu_write_out || (wr_en && hit_sctrl && pwdata[pegp_pkg::SCTRL_SET_OUT_FULL_BIT]);
  wire clr_out = ext_read_done || (wr_en && hit_sctrl && pwdata[pegp_pkg::SCTRL_CLR_OUT_FULL_BIT]);
  wire set_ovr = ext_write_done && in_full_reg && !cpu_read_in;
  wire clr_ovr = wr_en && hit_dir && !pwdata[pegp_pkg::DIR_OVERRUN_BIT];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_full_reg <= 1'b0;
      out_full_reg <= 1'b0;
      overrun_reg <= 1'b0;
    end else begin
      in_full_reg <= set_in | (in_full_reg & ~clr_in);
      out_full_reg <= set_out | (out_full_reg & ~clr_out);
      overrun_reg <= set_ovr | (overrun_reg & ~clr_ovr);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Interrupts: sticky, write one to clear, set wins
  wire hv_rise = line3_high_voltage && !hv_prev_reg;
  wire [3:0] irq_ev = {hv_rise, set_ovr, ext_read_done, ext_write_done};
  wire [3:0] irq_clr = (wr_en && hit_stat) ? pwdata[3:0] : 4'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= 4'h0;
      irq_mask_reg <= pegp_pkg::IRQ_MASK_RESET;
      hv_prev_reg <= 1'b0;
    end else begin
      irq_stat_reg <= irq_ev | (irq_stat_reg & ~irq_clr);
      hv_prev_reg <= line3_high_voltage;
      if (wr_en && hit_mask) begin
        irq_mask_reg <= pwdata[3:0];
      end
    end
  end
  assign irq = |(irq_stat_reg & irq_mask_reg);
endmodule

// ### pegp_port_sva.sv
// Checker for the upper port block
`timescale 1ns/10ps
module pegp_port_sva (
  // Clock, reset, APB
  input wire logic pclk, presetn, psel, penable, pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  // Lines and outside settings
  input wire logic [2:0] line_out, line_oe_n, analog_select,
  input wire logic line3_input, line3_high_voltage, external_reset_input,
  input wire logic prog_entry_detect, reset_pin_enable, slave_port_select
);
  // Access phase decode; pready never stalls
  wire wr = psel && penable && pwrite;
  wire rd = psel && penable && !pwrite;
  wire lat_wr = wr && (paddr == pegp_pkg::ADDR_PINS || paddr == pegp_pkg::ADDR_LATCH);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_dir_write: assert property (wr && paddr == pegp_pkg::ADDR_DIR |=> line_oe_n == $past(pwdata[2:0]))
    else $error("direction write not on drivers");
  a_oe_hold: assert property (!(wr && paddr == pegp_pkg::ADDR_DIR) |=> $stable(line_oe_n))
    else $error("drivers changed without write");
  a_latch_write: assert property (lat_wr |=> line_out == $past(pwdata[2:0]))
    else $error("latch write lost");
  a_latch_hold: assert property (!lat_wr |=> $stable(line_out))
    else $error("latch changed without write");
  a_analog_zero: assert property (rd && paddr == pegp_pkg::ADDR_PINS && $stable(analog_select)
    |-> (prdata[2:0] & analog_select) == 3'h0) else $error("analog line read nonzero");
  a_dir_unimpl: assert property (rd && paddr == pegp_pkg::ADDR_DIR |-> !prdata[3] && prdata[31:8] == 24'h0)
    else $error("unimplemented bits nonzero");
  a_mode_bit: assert property (rd && paddr == pegp_pkg::ADDR_DIR |-> prdata[4] == slave_port_select)
    else $error("mode bit mismatch");
  a_reset_pin: assert property ($stable(reset_pin_enable)
    |-> external_reset_input == (reset_pin_enable ? line3_input : 1'b1)) else $error("reset pin wrong");
  a_hv_detect: assert property (prog_entry_detect == line3_high_voltage)
    else $error("high voltage detect wrong");
endmodule
bind pegp_port pegp_port_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .line_out, .line_oe_n, .analog_select, .line3_input, .line3_high_voltage, .external_reset_input,
  .prog_entry_detect, .reset_pin_enable, .slave_port_select);

// ### tb_pegp_port.sv
// Self-checking bench for the upper port block
`timescale 1ns/10ps
module tb_pegp_port;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic line3_input, line3_high_voltage, external_reset_input, prog_entry_detect, reset_pin_enable;
  logic slave_rd_n, slave_wr_n, slave_cs_n, slave_port_select;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] line_in, line_out, line_oe_n, analog_select, host_en, host_val;
  logic [3:0] ev;
  int error_cnt, checks;
  pegp_port dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .line_in, .line_out, .line_oe_n, .line3_input, .line3_high_voltage, .external_reset_input,
    .prog_entry_detect, .analog_select, .reset_pin_enable, .slave_rd_n, .slave_wr_n, .slave_cs_n,
    .slave_port_select, .ext_write_done(ev[0]), .ext_read_done(ev[1]), .cpu_read_in(ev[2]),
    .cpu_write_out(ev[3]), .irq);
  pegp_pins pins (.line_out, .line_oe_n, .host_en, .host_val, .line_in);
  // 200 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; data and response taken at the ready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic pulse(input int i);
    @(posedge pclk);
    ev[i] <= 1'b1;
    @(posedge pclk);
    ev[i] <= 1'b0;
    tick(1);
  endtask
  task automatic t_reset;
    host_en <= 3'h7;
    host_val <= 3'h7;
    apb(0, pegp_pkg::ADDR_DIR, 0); chk(rd, 32'h07);
    apb(0, pegp_pkg::ADDR_PINS, 0); chk(rd & 32'h7, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_gpio;
    {analog_select, reset_pin_enable, line3_input, host_val} <= {3'h0, 1'b0, 1'b1, 3'h2};
    apb(1, pegp_pkg::ADDR_DIR, 32'hCA); apb(0, pegp_pkg::ADDR_DIR, 0); chk(rd, 32'h02);
    apb(1, pegp_pkg::ADDR_PINS, 32'h5); apb(0, pegp_pkg::ADDR_LATCH, 0); chk(rd, 32'h5);
    apb(0, pegp_pkg::ADDR_PINS, 0); chk(rd, 32'hF);
    analog_select <= 3'h4;
    tick(3);
    apb(0, pegp_pkg::ADDR_PINS, 0); chk(rd, 32'hB);
    chk({line_oe_n, line_out}, 32'h15);
    $display("gpio test done");
  endtask
  task automatic t_line3;
    {reset_pin_enable, line3_input, line3_high_voltage} <= 3'b101;
    tick(3); chk({external_reset_input, prog_entry_detect}, 32'h1);
    reset_pin_enable <= 1'b0;
    tick(3); chk(external_reset_input, 32'h1);
    $display("line3 test done");
  endtask
  task automatic t_slave;
    {analog_select, host_val} <= 6'h07;
    apb(1, pegp_pkg::ADDR_DIR, 32'h17); apb(1, pegp_pkg::ADDR_IRQ_MASK, 32'h1);
    host_val <= 3'h6;
    tick(3); chk({slave_port_select, slave_cs_n, slave_wr_n, slave_rd_n}, 32'hE);
    pulse(0); chk(irq, 32'h1);
    pulse(0); pulse(3);
    apb(0, pegp_pkg::ADDR_DIR, 0); chk(rd, 32'hF7);
    apb(1, pegp_pkg::ADDR_IRQ_STATUS, 32'hF); tick(1); chk(irq, 32'h0);
    apb(1, pegp_pkg::ADDR_DIR, 32'h17); pulse(2); pulse(1);
    apb(0, pegp_pkg::ADDR_DIR, 0); chk(rd, 32'h17);
    apb(0, 8'h20, 0); chk(err, 32'h1);
    chk(rd, 32'h0);
    $display("slave and unmapped test done");
  endtask
  task automatic results;
    $display("checks %0d, errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata, ev, host_en, host_val, line3_input, line3_high_voltage} = '0;
    {presetn, analog_select, reset_pin_enable, error_cnt, checks} = {1'b0, 3'h7, 1'b1, 64'h0};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_gpio;
    t_line3;
    t_slave;
    results;
  end
  // Tests need well under 1 us; the margin covers a stuck handshake
  initial begin
    #20000;
    error_cnt++;
    results;
  end
endmodule
